/* hdl/gpio_pkg.sv */
// Purpose: shared constants and carriers for the port logic block
// Assumes: registers are reached over apb, one aligned word per register
// Notes:   printed offsets are register indices; byte address = 4 * index
// Operation
// RQ1: every analog-shared pin has an output latch and its own direction bit.
// RQ2: software picks digital mode and input direction to read such a pin.
// RQ3: software picks digital mode and output direction to drive such a pin.
// RQ4: software hands analog-shared pins to digital use from the lowest bit up.
// RQ5: an analog input pin is converted only when the channel select names it.
// RQ6: software never sets analog mode together with output direction.
// RQ7: after reset every analog-shared pin is a digital input.
// RQ8: writing a data bit in output direction sets the latch that drives it.
// RQ9: reading a data bit in input direction returns the pin level.
// RQ10: ports that offer it have a per-pin software pull-up.
// RQ11: selected serial-shared inputs can switch to a ttl-threshold buffer.
// RQ12: selected serial-shared outputs can switch to open-drain drive.
// RQ13: the two i2c-shared pins always drive open-drain.
// RQ14: port 2 has eight pins with own direction bits, reset to digital inputs.
// RQ15: port 1 has four pins with own direction bits, reset to inputs.
// RQ16: port 7 has six pins with own direction bits, reset to inputs.
// RQ17: port 12 bits 1 to 4 are read-only and ignore writes.
package gpio_pkg;

  localparam int NPORT           = 12;
  localparam int PADDR_W         = 22;
  localparam int IDX_W           = 20;
  localparam int ANALOG_CHANNELS = 12;
  localparam int SLOT_PORT2      = 2;
  localparam int SLOT_PORT6      = 6;
  localparam int SLOT_PORT15     = 11;
  localparam int PORT2_BITS      = 8;
  localparam int PORT15_BITS     = 4;

  // data register indices, slot order 0..8, 12, 14, 15
  localparam logic [IDX_W-1:0] PORT0_DATA_IDX  = 20'hFFF00;
  localparam logic [IDX_W-1:0] PORT1_DATA_IDX  = 20'hFFF01;
  localparam logic [IDX_W-1:0] PORT2_DATA_IDX  = 20'hFFF02;
  localparam logic [IDX_W-1:0] PORT3_DATA_IDX  = 20'hFFF03;
  localparam logic [IDX_W-1:0] PORT4_DATA_IDX  = 20'hFFF04;
  localparam logic [IDX_W-1:0] PORT5_DATA_IDX  = 20'hFFF05;
  localparam logic [IDX_W-1:0] PORT6_DATA_IDX  = 20'hFFF06;
  localparam logic [IDX_W-1:0] PORT7_DATA_IDX  = 20'hFFF07;
  localparam logic [IDX_W-1:0] PORT8_DATA_IDX  = 20'hFFF08;
  localparam logic [IDX_W-1:0] PORT12_DATA_IDX = 20'hFFF0C;
  localparam logic [IDX_W-1:0] PORT14_DATA_IDX = 20'hFFF0E;
  localparam logic [IDX_W-1:0] PORT15_DATA_IDX = 20'hFFF0F;

  localparam logic [NPORT-1:0][IDX_W-1:0] PORT_DATA_IDX = {
    PORT15_DATA_IDX, PORT14_DATA_IDX, PORT12_DATA_IDX, PORT8_DATA_IDX,
    PORT7_DATA_IDX,  PORT6_DATA_IDX,  PORT5_DATA_IDX,  PORT4_DATA_IDX,
    PORT3_DATA_IDX,  PORT2_DATA_IDX,  PORT1_DATA_IDX,  PORT0_DATA_IDX};

  // per-slot configuration register bases; index = base + slot
  localparam logic [IDX_W-1:0] MODE_BASE_IDX   = 20'hFFF20;
  localparam logic [IDX_W-1:0] PULLUP_BASE_IDX = 20'hFFF30;
  localparam logic [IDX_W-1:0] ODSEL_BASE_IDX  = 20'hFFF40;
  localparam logic [IDX_W-1:0] TTLSEL_BASE_IDX = 20'hFFF50;
  localparam logic [IDX_W-1:0] ANALOG_DIGITAL_PIN_CONFIG_IDX        = 20'hFFF60;
  localparam logic [IDX_W-1:0] ADS_IDX         = 20'hFFF61;

  // implemented bits per slot
  localparam logic [NPORT-1:0][7:0] PORT_MASK = {
    8'h0F, 8'h01, 8'h1F, 8'h0F, 8'h3F, 8'h03,
    8'h07, 8'h03, 8'h07, 8'hFF, 8'h0F, 8'h03};
  localparam logic [NPORT-1:0][7:0] PULLUP_MASK = {
    8'h00, 8'h01, 8'h01, 8'h0F, 8'h3F, 8'h00,
    8'h07, 8'h03, 8'h07, 8'h00, 8'h0F, 8'h03};
  localparam logic [NPORT-1:0][7:0] ODSEL_MASK = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h2D, 8'h00,
    8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00};
  localparam logic [NPORT-1:0][7:0] TTLSEL_MASK = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h36, 8'h00,
    8'h00, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00};
  localparam logic [NPORT-1:0][7:0] FORCED_OD_MASK = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [NPORT-1:0][7:0] READ_ONLY_MASK = {
    8'h00, 8'h00, 8'h1E, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  localparam logic [7:0] DATA_RESET   = 8'h00;
  localparam logic [7:0] MODE_RESET   = 8'hFF;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [3:0] ANALOG_DIGITAL_PIN_CONFIG_RESET   = 4'hC;
  localparam logic [3:0] ADS_RESET    = 4'h0;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_en;
    logic [7:0] ttl_en;
    logic [7:0] analog_en;
  } pin_ctl_s;

endpackage : gpio_pkg

/* hdl/pin_drive.sv */
// Purpose: drive stage of one port, push-pull or open-drain per bit
// Assumes: latch and direction come from flip-flops
// Notes:   open-drain pulls low only; a high latch releases the pin
module pin_drive (
  // state
  input  wire logic [7:0] latch,
  input  wire logic [7:0] dir_in,
  input  wire logic [7:0] od_sel,
  input  wire logic [7:0] analog,
  // pin side
  output logic      [7:0] out,
  output logic      [7:0] oe
);
  wire logic [7:0] drive_en = ~dir_in & ~analog;

  assign out = latch & ~od_sel;                   // RQ8 RQ12
  assign oe  = drive_en & (~od_sel | ~latch);     // RQ12 RQ13
endmodule : pin_drive

/* hdl/analog_pin_ctrl.sv */
// Purpose: analog/digital pin split and converter channel selection
// Assumes: digital pins are counted from channel 0 upward
// Notes:   a count above the channel number is refused, keeping the old value
module analog_pin_ctrl
  import gpio_pkg::*;
(
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       sys_rst,
  // register writes
  input  wire logic                       wr_analog_digital_pin_config,
  input  wire logic                       wr_ads,
  input  wire logic [3:0]                 wdata,
  // channel directions, high is input
  input  wire logic [ANALOG_CHANNELS-1:0] chan_input,
  // state
  output logic      [3:0]                 analog_digital_pin_config_reg,
  output logic      [3:0]                 ads_reg,
  output logic      [ANALOG_CHANNELS-1:0] analog_mask,
  output logic      [ANALOG_CHANNELS-1:0] convert_sel
);
  wire logic analog_digital_pin_config_ok = wdata <= 4'(ANALOG_CHANNELS);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      analog_digital_pin_config_reg <= ANALOG_DIGITAL_PIN_CONFIG_RESET;                     // RQ7
      ads_reg  <= ADS_RESET;
    end else begin
      if (wr_analog_digital_pin_config && analog_digital_pin_config_ok) analog_digital_pin_config_reg <= wdata;  // RQ4
      if (wr_ads) ads_reg <= wdata;
    end
  end

  genvar c;
  generate
    for (c = 0; c < ANALOG_CHANNELS; c++) begin : g_chan
      assign analog_mask[c] = 4'(c) >= analog_digital_pin_config_reg;
      assign convert_sel[c] = analog_mask[c] && chan_input[c]
                              && ads_reg == 4'(c);  // RQ5
    end
  endgenerate
endmodule : analog_pin_ctrl

/* hdl/gpio_ports_analog_shared.sv */
// Purpose: general-purpose port registers, pin control and analog sharing
// Assumes: pin inputs are synchronous to ref_clk; apb with no wait states
// Notes:   read data is captured in the setup cycle, pready is always high
module gpio_ports_analog_shared
  import gpio_pkg::*;
(
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         sys_rst,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [PADDR_W-1:0]           paddr,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // pins
  input  wire logic [NPORT-1:0][7:0]        pin_in,
  output pin_ctl_s  [NPORT-1:0]             pin_ctl,
  // converter
  output logic      [3:0]                   adc_channel,
  output logic      [ANALOG_CHANNELS-1:0]   adc_convert_sel
);

  // bus decode
  wire logic             setup_ph = psel && !penable;
  wire logic             access   = psel && penable;
  wire logic             aligned  = paddr[1:0] == 2'b00;
  wire logic [IDX_W-1:0] idx      = paddr[PADDR_W-1:2];
  wire logic             wr_en    = access && pwrite && pstrb[0] && aligned;

  logic [NPORT-1:0]      hit_data;
  logic [NPORT-1:0]      hit_mode;
  logic [NPORT-1:0]      hit_pu;
  logic [NPORT-1:0]      hit_od;
  logic [NPORT-1:0]      hit_ttl;
  wire logic             hit_analog_digital_pin_config = aligned && idx == ANALOG_DIGITAL_PIN_CONFIG_IDX;
  wire logic             hit_ads  = aligned && idx == ADS_IDX;

  // per-port state
  logic [NPORT-1:0][7:0] latch_reg;
  logic [NPORT-1:0][7:0] dir_reg;
  logic [NPORT-1:0][7:0] pu_reg;
  logic [NPORT-1:0][7:0] od_reg;
  logic [NPORT-1:0][7:0] ttl_reg;
  logic [NPORT-1:0][7:0] analog;
  logic [NPORT-1:0][7:0] data_rd;
  logic [NPORT-1:0][7:0] drv_out;
  logic [NPORT-1:0][7:0] drv_oe;

  // analog sharing
  logic [3:0]                 analog_digital_pin_config_reg;
  logic [3:0]                 ads_reg;
  logic [ANALOG_CHANNELS-1:0] analog_mask;
  logic [ANALOG_CHANNELS-1:0] chan_input;

  // read path
  logic [31:0] rd_next;
  logic        hit_any;
  logic [31:0] prdata_reg;

  genvar s;
  generate
    for (s = 0; s < NPORT; s++) begin : g_port
      localparam logic [IDX_W-1:0] SOFF = IDX_W'(s);
      localparam logic [7:0]       VAL  = PORT_MASK[s];
      localparam logic [7:0]       RO   = READ_ONLY_MASK[s];
      localparam logic [7:0]       FOD  = FORCED_OD_MASK[s];

      logic [7:0] latch_next;
      logic [7:0] dir_next;
      logic [7:0] pu_next;
      logic [7:0] od_next;
      logic [7:0] ttl_next;
      logic [7:0] wmask;

      assign hit_data[s] = aligned && idx == PORT_DATA_IDX[s];
      assign hit_mode[s] = aligned && idx == MODE_BASE_IDX + SOFF;
      assign hit_pu[s]   = aligned && idx == PULLUP_BASE_IDX + SOFF;
      assign hit_od[s]   = aligned && idx == ODSEL_BASE_IDX + SOFF;
      assign hit_ttl[s]  = aligned && idx == TTLSEL_BASE_IDX + SOFF;

      // read-only bits keep their value, unimplemented bits stay zero
      assign wmask      = VAL & ~RO;                              // RQ17
      assign latch_next = (wr_en && hit_data[s])
                          ? (pwdata[7:0] & wmask) | (latch_reg[s] & RO)
                          : latch_reg[s];                         // RQ1 RQ8
      assign dir_next   = (wr_en && hit_mode[s])
                          ? (pwdata[7:0] & wmask) | (dir_reg[s] & RO)
                          : dir_reg[s];                           // RQ1
      assign pu_next    = (wr_en && hit_pu[s])
                          ? pwdata[7:0] & PULLUP_MASK[s]
                          : pu_reg[s];                            // RQ10
      assign od_next    = (wr_en && hit_od[s])
                          ? pwdata[7:0] & ODSEL_MASK[s]
                          : od_reg[s];                            // RQ12
      assign ttl_next   = (wr_en && hit_ttl[s])
                          ? pwdata[7:0] & TTLSEL_MASK[s]
                          : ttl_reg[s];                           // RQ11

      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          latch_reg[s] <= DATA_RESET;
          dir_reg[s]   <= MODE_RESET & VAL;    // RQ7 RQ14 RQ15 RQ16
          pu_reg[s]    <= CFG_RESET;
          od_reg[s]    <= CFG_RESET;
          ttl_reg[s]   <= CFG_RESET;
        end else begin
          latch_reg[s] <= latch_next;
          dir_reg[s]   <= dir_next;
          pu_reg[s]    <= pu_next;
          od_reg[s]    <= od_next;
          ttl_reg[s]   <= ttl_next;
        end
      end

      // an analog input pin has its digital input path cut, so it reads zero
      assign data_rd[s] = VAL & ((~dir_reg[s] & latch_reg[s])
                          | (dir_reg[s] & pin_in[s] & ~analog[s])); // RQ9

      pin_drive u_drive (
        .latch  (latch_reg[s]),
        // missing bits count as inputs so they are never driven
        .dir_in (dir_reg[s] | ~VAL),
        .od_sel (od_reg[s] | FOD),                        // RQ13
        .analog (analog[s]),
        .out    (drv_out[s]),
        .oe     (drv_oe[s])
      );

      // pull-up only acts while the pin is an input
      assign pin_ctl[s].out       = drv_out[s];
      assign pin_ctl[s].oe        = drv_oe[s];            // RQ3
      assign pin_ctl[s].pull_en   = pu_reg[s] & dir_reg[s];         // RQ10
      assign pin_ctl[s].ttl_en    = ttl_reg[s] & dir_reg[s];        // RQ11
      assign pin_ctl[s].analog_en = analog[s];
    end
  endgenerate

  // analog channels 0..7 sit on port 2, 8..11 on port 15
  generate
    for (s = 0; s < NPORT; s++) begin : g_amap
      if (s == SLOT_PORT2) begin : g_p2
        assign analog[s] = analog_mask[PORT2_BITS-1:0];
      end else if (s == SLOT_PORT15) begin : g_p15
        assign analog[s] = {4'h0,
          analog_mask[PORT2_BITS+PORT15_BITS-1:PORT2_BITS]};
      end else begin : g_dig
        assign analog[s] = 8'h00;
      end
    end
  endgenerate

  assign chan_input = {dir_reg[SLOT_PORT15][PORT15_BITS-1:0],
                       dir_reg[SLOT_PORT2]};

  analog_pin_ctrl u_analog (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .wr_analog_digital_pin_config     (wr_en && hit_analog_digital_pin_config),
    .wr_ads      (wr_en && hit_ads),
    .wdata       (pwdata[3:0]),
    .chan_input  (chan_input),
    .analog_digital_pin_config_reg    (analog_digital_pin_config_reg),
    .ads_reg     (ads_reg),
    .analog_mask (analog_mask),
    .convert_sel (adc_convert_sel)                        // RQ5
  );

  assign adc_channel = ads_reg;

  // read mux: at most one hit is ever high
  always_comb begin
    rd_next = 32'h0000_0000;
    hit_any = hit_analog_digital_pin_config || hit_ads;
    if (hit_analog_digital_pin_config) rd_next[3:0] = analog_digital_pin_config_reg;
    if (hit_ads)  rd_next[3:0] = ads_reg;
    for (int i = 0; i < NPORT; i++) begin
      hit_any = hit_any || hit_data[i] || hit_mode[i] || hit_pu[i]
                || hit_od[i] || hit_ttl[i];
      if (hit_data[i]) rd_next[7:0] = data_rd[i];
      if (hit_mode[i]) rd_next[7:0] = dir_reg[i];
      if (hit_pu[i])   rd_next[7:0] = pu_reg[i];
      if (hit_od[i])   rd_next[7:0] = od_reg[i];
      if (hit_ttl[i])  rd_next[7:0] = ttl_reg[i];
    end
  end

  // capture in setup keeps prdata a flop; pins sampled one cycle early
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_reg <= (pwrite || !hit_any) ? 32'h0000_0000 : rd_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = access && !hit_any;

endmodule : gpio_ports_analog_shared

/* verif/gpio_props.sv */
// Purpose: port-level checks of the gpio block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   sees only the top ports; bound after the module
module gpio_props
  import gpio_pkg::*;
(
  // clock and reset
  input wire logic                       ref_clk,
  input wire logic                       sys_rst,
  // apb
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [PADDR_W-1:0]         paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [3:0]                 pstrb,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // pins and converter
  input wire logic [NPORT-1:0][7:0]      pin_in,
  input wire pin_ctl_s [NPORT-1:0]       pin_ctl,
  input wire logic [3:0]                 adc_channel,
  input wire logic [ANALOG_CHANNELS-1:0] adc_convert_sel
);
  localparam logic [PADDR_W-1:0] A_P0  = {PORT0_DATA_IDX, 2'b00};
  localparam logic [PADDR_W-1:0] A_P14 = {PORT14_DATA_IDX, 2'b00};
  localparam logic [ANALOG_CHANNELS-1:0] ONE = 1;
  logic                       any_oe;
  logic                       any_an;
  logic                       an_drive;
  logic [ANALOG_CHANNELS-1:0] an_chan;
  assign an_chan = {pin_ctl[SLOT_PORT15].analog_en[3:0],
                    pin_ctl[SLOT_PORT2].analog_en};
  always_comb begin
    any_oe = 1'b0;
    any_an = 1'b0;
    an_drive = 1'b0;
    for (int s = 0; s < NPORT; s++) begin
      any_oe = any_oe | (|pin_ctl[s].oe);
      any_an = any_an | (|pin_ctl[s].analog_en);
      an_drive = an_drive | (|(pin_ctl[s].oe & pin_ctl[s].analog_en));
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_p0_write;
    psel && penable && pwrite && pstrb[0] && paddr == A_P0;
  endsequence
  sequence s_p14_read;
    psel && !penable && !pwrite && paddr == A_P14 && !pin_ctl[10].oe[0];
  endsequence
  a_rst_no_drive: assert property ($fell(sys_rst) |-> !any_oe && !any_an)
    else $error("pins driven or analog after reset");
  a_rst_no_conv: assert property (
    $fell(sys_rst) |-> adc_convert_sel == '0)
    else $error("conversion selected after reset");
  a_conv_named: assert property (|adc_convert_sel |->
    adc_convert_sel == (ONE << adc_channel))
    else $error("converted channel differs from selection");
  a_conv_analog: assert property ((adc_convert_sel & ~an_chan) == '0)
    else $error("digital channel marked for conversion");
  a_analog_quiet: assert property (!an_drive)
    else $error("analog pin driven");
  a_i2c_od: assert property (
    (pin_ctl[SLOT_PORT6].oe[1:0] & pin_ctl[SLOT_PORT6].out[1:0]) == 2'b00)
    else $error("i2c pin driven high");
  a_osc_ro: assert property (pin_ctl[9].oe[4:1] == 4'h0)
    else $error("oscillator pin driven");
  a_latch_drive: assert property (s_p0_write ##1 pin_ctl[0].oe[0]
    |-> pin_ctl[0].out[0] == $past(pwdata[0]))
    else $error("latch write not on pin");
  a_pin_read: assert property (s_p14_read |=>
    prdata[0] == $past(pin_in[10][0]))
    else $error("pin level not read back");
endmodule : gpio_props

bind gpio_ports_analog_shared gpio_props i_props (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
  .pin_ctl(pin_ctl), .adc_channel(adc_channel),
  .adc_convert_sel(adc_convert_sel));

/* verif/pin_board.sv */
// Purpose: board model of the port pins
// Assumes: bench may drive any pin; a pin the block drives takes the block's level
// Notes:   a floating pin toggles so a stale level never reads back
module pin_board
  import gpio_pkg::*;
(
  // clock
  input  wire logic                  ref_clk,
  // block side
  input  wire pin_ctl_s [NPORT-1:0]  pin_ctl,
  // board side
  input  wire logic [NPORT-1:0][7:0] ext_en,
  input  wire logic [NPORT-1:0][7:0] ext_val,
  output logic      [NPORT-1:0][7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] float_pat = 8'h55;
  always @(posedge ref_clk) float_pat <= ~float_pat;
  always_comb begin
    for (int s = 0; s < NPORT; s++) begin
      for (int b = 0; b < 8; b++) begin
        if (pin_ctl[s].oe[b]) begin
          pin_in[s][b] = pin_ctl[s].out[b];
        end else if (ext_en[s][b]) begin
          pin_in[s][b] = ext_val[s][b];
        end else if (pin_ctl[s].pull_en[b]) begin
          pin_in[s][b] = 1'b1;
        end else begin
          pin_in[s][b] = float_pat[b];
        end
      end
    end
  end
endmodule : pin_board

/* verif/gpio_ports_analog_shared_tb.sv */
// Purpose: self-checking bench for the gpio port block
// Assumes: apb answers whenever pready is high; board model on the pins
// Notes:   byte address is four times the register index
module gpio_ports_analog_shared_tb
  import gpio_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic                       ref_clk, sys_rst, psel, penable, pwrite, err;
  logic [PADDR_W-1:0]         paddr;
  logic [31:0]                pwdata, prdata, rd;
  logic [3:0]                 pstrb, adc_channel;
  logic                       pready, pslverr;
  logic [NPORT-1:0][7:0]      pin_in, ext_en, ext_val;
  pin_ctl_s [NPORT-1:0]       pin_ctl;
  logic [ANALOG_CHANNELS-1:0] adc_convert_sel;
  int                         mismatches, n_checks;
  gpio_ports_analog_shared i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_ctl(pin_ctl),
    .adc_channel(adc_channel), .adc_convert_sel(adc_convert_sel));
  pin_board i_board (.ref_clk(ref_clk), .pin_ctl(pin_ctl), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic chk_pin(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : chk_pin
  task automatic chk_reg(string what, logic [7:0] exp);
    n_checks++;
    if (rd !== {24'h0, exp}) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", what, exp, rd);
    end
  endtask : chk_reg
  // request held from setup until pready is seen high at an edge
  task automatic apb(logic w, logic [IDX_W-1:0] idx, logic [7:0] d);
    int n;
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      summarize();
    end
  endtask : apb
  task automatic t_reset();
    for (int s = 0; s < NPORT; s++) begin
      apb(1'b0, MODE_BASE_IDX + IDX_W'(s), 8'h00);
      chk_reg("dir", PORT_MASK[s]);
      apb(1'b0, PORT_DATA_IDX[s], 8'h00);
      chk_reg("data", 8'h00);
    end
    apb(1'b0, ANALOG_DIGITAL_PIN_CONFIG_IDX, 8'h00);
    chk_reg("analog_digital_pin_config", 8'h0C);
  endtask : t_reset
  task automatic t_drive();
    logic [7:0] od;
    for (int s = 0; s < NPORT; s++) begin
      if (s == 9) continue;
      od = FORCED_OD_MASK[s];
      apb(1'b1, MODE_BASE_IDX + IDX_W'(s), 8'h00);
      apb(1'b1, PORT_DATA_IDX[s], 8'hA5);
      #1;
      chk_pin("oe", PORT_MASK[s] & ~(od & 8'hA5), pin_ctl[s].oe);
      chk_pin("out", PORT_MASK[s] & ~od & 8'hA5, pin_ctl[s].out);
      apb(1'b0, PORT_DATA_IDX[s], 8'h00);
      chk_reg("latch", PORT_MASK[s] & 8'hA5);
    end
  endtask : t_drive
  task automatic t_read();
    for (int s = 0; s < NPORT; s++) begin
      apb(1'b1, MODE_BASE_IDX + IDX_W'(s), 8'hFF);
    end
    @(posedge ref_clk);
    ext_val <= {NPORT{8'h3C}};
    for (int s = 0; s < NPORT; s++) begin
      apb(1'b0, PORT_DATA_IDX[s], 8'h00);
      chk_reg("pin", PORT_MASK[s] & 8'h3C);
    end
    @(posedge ref_clk);
    ext_en[1] <= 8'h00;
    apb(1'b1, PULLUP_BASE_IDX + 20'h1, 8'hFF);
    #1;
    chk_pin("pull", PULLUP_MASK[1], pin_ctl[1].pull_en);
    apb(1'b0, PORT1_DATA_IDX, 8'h00);
    chk_reg("pulled", PULLUP_MASK[1]);
  endtask : t_read
  task automatic t_serial();
    apb(1'b1, ODSEL_BASE_IDX + 20'h3, 8'hFF);
    apb(1'b1, TTLSEL_BASE_IDX + 20'h3, 8'hFF);
    #1;
    chk_pin("ttl", TTLSEL_MASK[3], pin_ctl[3].ttl_en);
    apb(1'b1, PORT3_DATA_IDX, 8'h05);
    apb(1'b1, MODE_BASE_IDX + 20'h3, 8'h00);
    #1;
    chk_pin("od oe", ODSEL_MASK[3] & ~8'h05, pin_ctl[3].oe);
    chk_pin("od out", 8'h00, pin_ctl[3].out);
  endtask : t_serial
  task automatic t_analog();
    // port 15 pins are still inputs, so going analog is a legal pairing
    apb(1'b1, ANALOG_DIGITAL_PIN_CONFIG_IDX, 8'h08);
    apb(1'b1, ADS_IDX, 8'h09);
    #1;
    chk_pin("an", 8'h0F, pin_ctl[SLOT_PORT15].analog_en);
    chk_pin("an p2", 8'h00, pin_ctl[SLOT_PORT2].analog_en);
    chk_pin("conv", 8'h02, {4'h0, adc_convert_sel[11:8]});
    apb(1'b0, PORT15_DATA_IDX, 8'h00);
    chk_reg("an read", 8'h00);
    apb(1'b1, ADS_IDX, 8'h03);
    #1;
    chk_pin("ch", 8'h03, {4'h0, adc_channel});
    chk_pin("no conv", 8'h00, adc_convert_sel[7:0]);
  endtask : t_analog
  task automatic t_osc();
    apb(1'b1, MODE_BASE_IDX + 20'h9, 8'h00);
    apb(1'b1, PORT12_DATA_IDX, 8'hFF);
    #1;
    chk_pin("p12 oe", 8'h01, pin_ctl[9].oe);
    apb(1'b0, PORT12_DATA_IDX, 8'h00);
    chk_reg("p12", 8'h1D);
    apb(1'b0, 20'hFFF70, 8'h00);
    chk_pin("slverr", 8'h01, {7'h0, err});
    chk_reg("unmapped", 8'h00);
  endtask : t_osc
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite} = 3'b000;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h1;
    ext_en = '1;
    ext_val = '0;
    mismatches = 0;
    n_checks = 0;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_drive();
    t_read();
    t_serial();
    t_analog();
    t_osc();
    summarize();
  end
endmodule : gpio_ports_analog_shared_tb
